//--- logic/ccrb_register_bank.sv
// ccrb_register_bank: the charger's six control and status registers,
// their read side effects and the decoded settings they drive.
// assumes: a serial engine on clk hands over register accesses as single
// cycle strobes; all analog status inputs are asynchronous to clk.
//
// Notes on behaviour
// - charge state in 0x00 bits 7:6, present condition only
// - 0x00 bit 5 write-only, resets 0, 1 requests storage state
// - 0x00 bit 4 set on push-button reset, cleared after read
// - 0x00 bit 3 timer fault survives reads, clears on disable toggle or power
// - 0x00 bits 2:0 live: power limit, disable pin, switcher on
// - 0x01 bit 7 overvoltage keeps reading 1 while it persists
// - 0x01 bit 6 undervoltage reported once per new event, clear on read
// - 0x01 bit 5 battery lockout keeps reading 1 while present
// - 0x01 bit 4 battery overcurrent cleared after a read
// - mask bits reset 0; a 1 suppresses signalling of that condition
// - 0x02 bit 7 resets 1, enables thermistor monitoring
// - 0x02 bits 6:5 temperature zone: normal, cold/hot, cool, warm
// - 0x02 bit 4 open thermistor; stops charge when option enabled
// - 0x02 bit 3 resets 1: interrupt shows faults plus charge status
// - charge current 5+code mA or 40+10*code mA by range bit
// - charge current saturates at 35 or 300 mA; all ones selects external
// - 0x03 bit 1 disables charger, bit 0 high impedance; both reset 0
// - termination 0.5+0.5*code mA or 6+code mA by range bit
// - low termination range saturates at 5 mA
// - 0x04 bit 1 resets 1 enabling termination, inhibited under other loops
// - regulation voltage 3.6 V plus code*10 mV, saturating at 4.65 V
// - reads outside the map return 0xFF
`timescale 1ns/1ps

module ccrb_register_bank (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rdata,
  input wire logic [1:0] charge_state_in,
  input wire logic reset_cond_in,
  input wire logic wake_cond_in,
  input wire logic timer_fault_in,
  input wire logic input_power_limit_active,
  input wire logic chip_disable_pin,
  input wire logic switcher_on,
  input wire logic input_overvoltage,
  input wire logic below_sleep_threshold,
  input wire logic battery_lockout,
  input wire logic battery_overcurrent,
  input wire logic [1:0] temperature_zone_in,
  input wire logic thermistor_open_in,
  input wire logic open_thermistor_stop_option,
  output logic storage_state_request,
  output logic charger_disable,
  output logic high_impedance_request,
  output logic thermistor_enable,
  output logic charge_stop,
  output logic use_external_current,
  output logic [8:0] charge_current_ma,
  output logic charge_current_halved,
  output logic [6:0] termination_half_ma,
  output logic termination_active,
  output logic [12:0] battery_target_voltage,
  output logic interrupt_request
);

  // ==========================================================
  // synchronisers: stage a feeds stage b only
  typedef struct packed {
    logic [1:0] charge_state;
    logic reset_cond;
    logic wake_cond;
    logic timer_fault;
    logic power_limit;
    logic disable_pin;
    logic switcher;
    logic ov;
    logic uv;
    logic lockout;
    logic ocp;
    logic [1:0] zone;
    logic open;
    logic open_opt;
  } ccrb_inputs_type;

  typedef struct packed {
    ccrb_inputs_type sync_a;
    ccrb_inputs_type sync_b;
    ccrb_inputs_type prev;
    logic storage_state_request;
    logic reset_fault_flag;
    logic wake_flag;
    logic timer_flag;
    logic input_overvoltage_flag;
    logic input_undervoltage_flag;
    logic battery_lockout_flag;
    logic battery_overcurrent_flag;
    logic [3:0] fault_mask;
    logic [7:0] therm_ctrl;
    logic [7:0] fast_charge;
    logic [7:0] term_ctrl;
    logic [7:0] vbat_ctrl;
    logic [7:0] rdata;
    logic status_event;
  } ccrb_state_type;

  ccrb_state_type st_r;
  ccrb_state_type st_nxt;
  ccrb_inputs_type raw_in;

  assign raw_in = '{
    charge_state: charge_state_in,
    reset_cond: reset_cond_in,
    wake_cond: wake_cond_in,
    timer_fault: timer_fault_in,
    power_limit: input_power_limit_active,
    disable_pin: chip_disable_pin,
    switcher: switcher_on,
    ov: input_overvoltage,
    uv: below_sleep_threshold,
    lockout: battery_lockout,
    ocp: battery_overcurrent,
    zone: temperature_zone_in,
    open: thermistor_open_in,
    open_opt: open_thermistor_stop_option
  };

  // ==========================================================
  // decoders
  function automatic logic [8:0] ccrb_charge_ma(input logic [7:0] r);
    logic [4:0] code;
    logic [8:0] hi;
    code = r[ccrb_pkg::CODE_LSB +: 5];
    hi = ccrb_pkg::ICHG_HI_BASE_MA + 9'(code) * ccrb_pkg::ICHG_HI_STEP_MA;
    if (!r[ccrb_pkg::RANGE_BIT]) begin
      ccrb_charge_ma = ccrb_pkg::ICHG_LO_BASE_MA + 9'(code);
      if (ccrb_charge_ma > ccrb_pkg::ICHG_LO_MAX_MA) begin
        ccrb_charge_ma = ccrb_pkg::ICHG_LO_MAX_MA;
      end
    end else begin
      ccrb_charge_ma = (hi > ccrb_pkg::ICHG_HI_MAX_MA) ?
                       ccrb_pkg::ICHG_HI_MAX_MA : hi;
    end
  endfunction

  function automatic logic [6:0] ccrb_term_half_ma(input logic [7:0] r);
    logic [6:0] code;
    code = 7'(r[ccrb_pkg::CODE_LSB +: 5]);
    if (!r[ccrb_pkg::RANGE_BIT]) begin
      ccrb_term_half_ma = ccrb_pkg::ITERM_LO_BASE + code;
      if (ccrb_term_half_ma > ccrb_pkg::ITERM_LO_MAX) begin
        ccrb_term_half_ma = ccrb_pkg::ITERM_LO_MAX;
      end
    end else begin
      ccrb_term_half_ma = ccrb_pkg::ITERM_HI_BASE
                          + 7'(code * ccrb_pkg::ITERM_HI_STEP);
    end
  endfunction

  function automatic logic [12:0] ccrb_vbat_mv(input logic [7:0] r);
    logic [12:0] v;
    v = ccrb_pkg::VBAT_BASE_MV
        + 13'(r[ccrb_pkg::VCODE_LSB +: 7]) * ccrb_pkg::VBAT_STEP_MV;
    ccrb_vbat_mv = (v > ccrb_pkg::VBAT_MAX_MV) ? ccrb_pkg::VBAT_MAX_MV : v;
  endfunction

  // ==========================================================
  // read images
  logic [7:0] status_img;
  logic [7:0] fault_img;
  logic [7:0] therm_img;
  logic [1:0] zone_live;

  always_comb begin
    zone_live = st_r.sync_b.zone;
    status_img = {st_r.sync_b.charge_state,
                  1'b0,
                  st_r.reset_fault_flag,
                  st_r.timer_flag,
                  st_r.sync_b.power_limit,
                  st_r.sync_b.disable_pin,
                  st_r.sync_b.switcher};
    fault_img = {st_r.input_overvoltage_flag,
                 st_r.input_undervoltage_flag,
                 st_r.battery_lockout_flag,
                 st_r.battery_overcurrent_flag,
                 st_r.fault_mask};
    therm_img = {st_r.therm_ctrl[ccrb_pkg::THERM_EN_BIT],
                 zone_live,
                 st_r.sync_b.open,
                 st_r.therm_ctrl[3:0]};
  end

  // ==========================================================
  // next state
  logic rd_status;
  logic rd_fault;
  logic wr_hit;
  logic cd_toggle;

  always_comb begin
    st_nxt = st_r;
    st_nxt.sync_a = raw_in;
    st_nxt.sync_b = st_r.sync_a;
    st_nxt.prev = st_r.sync_b;
    rd_status = reg_rd_en && (reg_addr == ccrb_pkg::OFS_STATUS);
    rd_fault = reg_rd_en && (reg_addr == ccrb_pkg::OFS_FAULT);
    wr_hit = reg_wr_en;
    cd_toggle = st_r.sync_b.disable_pin != st_r.prev.disable_pin;

    // clear on read, a new event in the same cycle wins
    st_nxt.reset_fault_flag = (st_r.reset_fault_flag && !rd_status)
                              || (st_r.sync_b.reset_cond && !st_r.prev.reset_cond);
    st_nxt.wake_flag = st_r.wake_flag
                       || (st_r.sync_b.wake_cond && !st_r.prev.wake_cond);
    if (rd_status && !(st_r.sync_b.wake_cond && !st_r.prev.wake_cond)) begin
      st_nxt.wake_flag = 1'b0;
    end
    // reads leave the timer fault alone
    st_nxt.timer_flag = (st_r.timer_flag && !cd_toggle)
                        || st_r.sync_b.timer_fault;
    st_nxt.input_overvoltage_flag = st_r.sync_b.ov
                                    || (st_r.input_overvoltage_flag && !rd_fault);
    st_nxt.input_undervoltage_flag = (st_r.sync_b.uv && !st_r.prev.uv)
                                     || (st_r.input_undervoltage_flag && !rd_fault);
    st_nxt.battery_lockout_flag = st_r.sync_b.lockout
                                  || (st_r.battery_lockout_flag && !rd_fault);
    st_nxt.battery_overcurrent_flag = (st_r.sync_b.ocp && !st_r.prev.ocp)
                                      || (st_r.battery_overcurrent_flag && !rd_fault);

    if (wr_hit) begin
      case (reg_addr)
        ccrb_pkg::OFS_STATUS: st_nxt.storage_state_request =
                                reg_wdata[ccrb_pkg::STORAGE_BIT];
        ccrb_pkg::OFS_FAULT: st_nxt.fault_mask = reg_wdata[3:0];
        ccrb_pkg::OFS_THERM: st_nxt.therm_ctrl = reg_wdata;
        ccrb_pkg::OFS_FCHG: st_nxt.fast_charge = reg_wdata;
        ccrb_pkg::OFS_TERM: st_nxt.term_ctrl = reg_wdata;
        ccrb_pkg::OFS_VBAT: st_nxt.vbat_ctrl = reg_wdata;
        default: st_nxt.rdata = st_r.rdata;
      endcase
    end

    if (reg_rd_en) begin
      case (reg_addr)
        ccrb_pkg::OFS_STATUS: st_nxt.rdata = status_img;
        ccrb_pkg::OFS_FAULT: st_nxt.rdata = fault_img;
        ccrb_pkg::OFS_THERM: st_nxt.rdata = therm_img;
        ccrb_pkg::OFS_FCHG: st_nxt.rdata = st_r.fast_charge;
        ccrb_pkg::OFS_TERM: st_nxt.rdata = st_r.term_ctrl;
        ccrb_pkg::OFS_VBAT: st_nxt.rdata = st_r.vbat_ctrl;
        default: st_nxt.rdata = ccrb_pkg::UNMAPPED_READ;
      endcase
    end

    // charge status changes feed the interrupt only while enabled
    st_nxt.status_event = (st_r.sync_b.charge_state != st_r.prev.charge_state)
                          && st_r.therm_ctrl[ccrb_pkg::EN_INT_BIT];
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.fault_mask <= ccrb_pkg::RST_FAULT_MASK;
      st_r.therm_ctrl <= ccrb_pkg::RST_THERM_CTRL;
      st_r.fast_charge <= ccrb_pkg::RST_FCHG;
      st_r.term_ctrl <= ccrb_pkg::RST_TERM;
      st_r.vbat_ctrl <= ccrb_pkg::RST_VBAT;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs
  logic [8:0] ichg_full;
  logic [12:0] vbat_full;
  logic zone_on;

  assign reg_rdata = st_r.rdata;
  assign storage_state_request = st_r.storage_state_request;
  assign charger_disable = st_r.fast_charge[ccrb_pkg::CE_BIT];
  assign high_impedance_request = st_r.fast_charge[ccrb_pkg::HZ_BIT];
  assign thermistor_enable = st_r.therm_ctrl[ccrb_pkg::THERM_EN_BIT];
  assign zone_on = st_r.therm_ctrl[ccrb_pkg::THERM_EN_BIT];
  assign ichg_full = ccrb_charge_ma(st_r.fast_charge);
  assign use_external_current =
    st_r.fast_charge[ccrb_pkg::CODE_LSB +: 5] == ccrb_pkg::CODE_EXTERNAL;
  assign charge_current_ma = ichg_full;
  assign charge_current_halved = zone_on && (st_r.sync_b.zone == ccrb_pkg::ZONE_COOL);
  // halving is left to the analog loop; the code stays as programmed
  assign charge_stop = (st_r.sync_b.open && st_r.sync_b.open_opt)
                       || (zone_on && st_r.sync_b.zone == ccrb_pkg::ZONE_COLD_HOT);
  assign termination_half_ma = ccrb_term_half_ma(st_r.term_ctrl);
  assign termination_active = st_r.term_ctrl[ccrb_pkg::TE_BIT]
                              && !st_r.sync_b.power_limit
                              && !charge_current_halved;
  assign vbat_full = ccrb_vbat_mv(st_r.vbat_ctrl);
  assign battery_target_voltage =
    (zone_on && st_r.sync_b.zone == ccrb_pkg::ZONE_WARM) ?
    vbat_full - ccrb_pkg::VBAT_WARM_DROP_MV : vbat_full;
  // masked conditions never reach the interrupt line
  assign interrupt_request =
    (st_r.input_overvoltage_flag && !st_r.fault_mask[3])
    || (st_r.input_undervoltage_flag && !st_r.fault_mask[2])
    || (st_r.battery_lockout_flag && !st_r.fault_mask[1])
    || (st_r.battery_overcurrent_flag && !st_r.fault_mask[0])
    || (st_r.wake_flag && !st_r.therm_ctrl[2])
    || (st_r.reset_fault_flag && !st_r.therm_ctrl[1])
    || (st_r.timer_flag && !st_r.therm_ctrl[0])
    || st_r.status_event;

endmodule

//--- shared/ccrb_pkg.sv
// ccrb_pkg: offsets, reset values, field positions and scaling constants
// for the charger control register bank.
// assumes: referenced by the register bank only, the bench uses literals; no imports.
package ccrb_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_FAULT = 8'h01;
  localparam logic [7:0] OFS_THERM = 8'h02;
  localparam logic [7:0] OFS_FCHG = 8'h03;
  localparam logic [7:0] OFS_TERM = 8'h04;
  localparam logic [7:0] OFS_VBAT = 8'h05;
  localparam logic [7:0] UNMAPPED_READ = 8'hFF;

  // ==========================================================
  // reset values of the writable parts
  localparam logic [3:0] RST_FAULT_MASK = 4'h0;
  localparam logic [7:0] RST_THERM_CTRL = 8'h88;
  localparam logic [7:0] RST_FCHG = 8'h14;
  localparam logic [7:0] RST_TERM = 8'h0E;
  localparam logic [7:0] RST_VBAT = 8'h78;

  // ==========================================================
  // field positions
  localparam int STORAGE_BIT = 5;
  localparam int THERM_EN_BIT = 7;
  localparam int EN_INT_BIT = 3;
  localparam int RANGE_BIT = 7;
  localparam int CODE_LSB = 2;
  localparam int CE_BIT = 1;
  localparam int HZ_BIT = 0;
  localparam int TE_BIT = 1;
  localparam int VCODE_LSB = 1;

  // ==========================================================
  // charge states and temperature zones
  localparam logic [1:0] CHG_READY = 2'h0;
  localparam logic [1:0] CHG_ACTIVE = 2'h1;
  localparam logic [1:0] CHG_DONE = 2'h2;
  localparam logic [1:0] CHG_FAULT = 2'h3;
  localparam logic [1:0] ZONE_NORMAL = 2'h0;
  localparam logic [1:0] ZONE_COLD_HOT = 2'h1;
  localparam logic [1:0] ZONE_COOL = 2'h2;
  localparam logic [1:0] ZONE_WARM = 2'h3;

  // ==========================================================
  // current and voltage scaling
  localparam logic [4:0] CODE_EXTERNAL = 5'h1F;
  localparam logic [8:0] ICHG_LO_BASE_MA = 9'h005;
  localparam logic [8:0] ICHG_LO_MAX_MA = 9'h023;
  localparam logic [8:0] ICHG_HI_BASE_MA = 9'h028;
  localparam logic [8:0] ICHG_HI_STEP_MA = 9'h00A;
  localparam logic [8:0] ICHG_HI_MAX_MA = 9'h12C;
  // termination in 500 uA units
  localparam logic [6:0] ITERM_LO_BASE = 7'h01;
  localparam logic [6:0] ITERM_LO_MAX = 7'h0A;
  localparam logic [6:0] ITERM_HI_BASE = 7'h0C;
  localparam logic [6:0] ITERM_HI_STEP = 7'h02;
  localparam logic [12:0] VBAT_BASE_MV = 13'h0E10;
  localparam logic [12:0] VBAT_STEP_MV = 13'h000A;
  localparam logic [12:0] VBAT_MAX_MV = 13'h122A;
  localparam logic [12:0] VBAT_WARM_DROP_MV = 13'h008C;

endpackage

//--- testbench/ccrb_chk.sv
// ccrb_chk: port-level assertions for the charger register bank.
// assumes: bound to ccrb_register_bank; one clock, synchronous reset.
`timescale 1ns/1ps
module ccrb_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_rdata,
  input wire logic input_overvoltage,
  input wire logic battery_overcurrent,
  input wire logic storage_state_request,
  input wire logic charger_disable,
  input wire logic high_impedance_request,
  input wire logic thermistor_enable,
  input wire logic use_external_current,
  input wire logic [8:0] charge_current_ma,
  input wire logic [6:0] termination_half_ma
);
  // ==========================================================
  // helpers
  logic [7:0] wd_q;
  always_ff @(posedge clk) wd_q <= reg_wdata;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_fault_rd;
    reg_rd_en && reg_addr == 8'h01;
  endsequence
  // input quiet long enough that no rising edge survives the synchroniser
  sequence s_ocp_quiet;
    (!battery_overcurrent) [*6];
  endsequence
  // ==========================================================
  // properties
  property p_unmapped;
    reg_rd_en && reg_addr > 8'h05 |=> reg_rdata == 8'hFF;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not FF");
  property p_storage;
    reg_wr_en && reg_addr == 8'h00 |=> storage_state_request == wd_q[5];
  endproperty
  a_storage: assert property (p_storage) else $error("storage request wrong");
  property p_ce_hz;
    reg_wr_en && reg_addr == 8'h03 |=> {charger_disable, high_impedance_request} == wd_q[1:0];
  endproperty
  a_ce_hz: assert property (p_ce_hz) else $error("disable or hi-z wrong");
  property p_thermistor_enable;
    reg_wr_en && reg_addr == 8'h02 |=> thermistor_enable == wd_q[7];
  endproperty
  a_thermistor_enable: assert property (p_thermistor_enable) else $error("thermistor enable wrong");
  property p_ext;
    reg_wr_en && reg_addr == 8'h03 && reg_wdata[6:2] == 5'h1F |=> use_external_current;
  endproperty
  a_ext: assert property (p_ext) else $error("external current not chosen");
  property p_ilo;
    reg_wr_en && reg_addr == 8'h03 && !reg_wdata[7] && reg_wdata[6:2] != 5'h1F
      |=> charge_current_ma == 9'h005 + {4'h0, wd_q[6:2]};
  endproperty
  a_ilo: assert property (p_ilo) else $error("low range current wrong");
  property p_term_sat;
    reg_wr_en && reg_addr == 8'h04 && !reg_wdata[7] && reg_wdata[6:2] > 5'h08
      |=> termination_half_ma == 7'h0A;
  endproperty
  a_term_sat: assert property (p_term_sat) else $error("termination not saturated");
  property p_ov_hold;
    input_overvoltage [*5] ##0 s_fault_rd |=> reg_rdata[7];
  endproperty
  a_ov_hold: assert property (p_ov_hold) else $error("overvoltage flag lost");
  property p_ocp_clear;
    s_ocp_quiet ##0 s_fault_rd ##1 s_fault_rd |=> !reg_rdata[4];
  endproperty
  a_ocp_clear: assert property (p_ocp_clear) else $error("overcurrent not cleared");
endmodule

bind ccrb_register_bank ccrb_chk u_chk (.clk, .rst, .reg_addr, .reg_wr_en, .reg_wdata,
  .reg_rd_en, .reg_rdata, .input_overvoltage, .battery_overcurrent, .storage_state_request,
  .charger_disable, .high_impedance_request, .thermistor_enable, .use_external_current,
  .charge_current_ma, .termination_half_ma);

//--- testbench/ccrb_host.sv
// ccrb_host: register-side host model issuing byte strobes.
// assumes: tasks are called from the bench at a falling clock edge.
`timescale 1ns/1ps
module ccrb_host (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic reg_wr_en,
  output logic [7:0] reg_wdata,
  output logic reg_rd_en,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wdata = 8'h00;
    reg_rd_en = 1'b0;
  end
  // ==========================================================
  // accesses; released data is inverted so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clk);
    reg_wr_en = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(negedge clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge clk);
    reg_rd_en = 1'b0;
    q = reg_rdata;
  endtask
  // two reads of one address in consecutive cycles
  task automatic rd2(input logic [7:0] a, output logic [7:0] q1, output logic [7:0] q2);
    @(negedge clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge clk);
    q1 = reg_rdata;
    @(negedge clk);
    reg_rd_en = 1'b0;
    q2 = reg_rdata;
  endtask
endmodule

//--- testbench/tb_top.sv
// tb_top: directed scenarios for the charger register bank.
// assumes: ccrb_host drives the strobes; the bench drives sensed levels.
`timescale 1ns/1ps
module tb_top;
  logic clk, rst, reg_wr_en, reg_rd_en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, q, q2;
  logic [1:0] charge_state_in, temperature_zone_in;
  logic reset_cond_in, wake_cond_in, timer_fault_in, input_power_limit_active;
  logic chip_disable_pin, switcher_on, input_overvoltage, below_sleep_threshold;
  logic battery_lockout, battery_overcurrent, thermistor_open_in, open_thermistor_stop_option;
  logic storage_state_request, charger_disable, high_impedance_request, thermistor_enable;
  logic charge_stop, use_external_current, charge_current_halved, termination_active;
  logic interrupt_request;
  logic [8:0] charge_current_ma;
  logic [6:0] termination_half_ma;
  logic [12:0] battery_target_voltage;
  int bad_count, total_checks, e;
  ccrb_register_bank dut (.clk, .rst, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en,
    .reg_rdata, .charge_state_in, .reset_cond_in, .wake_cond_in, .timer_fault_in,
    .input_power_limit_active, .chip_disable_pin, .switcher_on, .input_overvoltage,
    .below_sleep_threshold, .battery_lockout, .battery_overcurrent, .temperature_zone_in,
    .thermistor_open_in, .open_thermistor_stop_option, .storage_state_request,
    .charger_disable, .high_impedance_request, .thermistor_enable, .charge_stop,
    .use_external_current, .charge_current_ma, .charge_current_halved, .termination_half_ma,
    .termination_active, .battery_target_voltage, .interrupt_request);
  ccrb_host host (.clk, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en, .reg_rdata);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ==========================================================
  // compares and closing
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkv(input logic [12:0] got, input logic [12:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // sensed levels pass a two-flop synchroniser, so settle before looking
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    logic [7:0] exp [6];
    exp = '{8'h01, 8'h00, 8'h88, 8'h14, 8'h0E, 8'h78};
    for (int i = 0; i < 6; i++) begin
      host.rd(i[7:0], q);
      chk8(q, exp[i]);
    end
    host.wr(8'h06, 8'h00);
    host.rd(8'h06, q);
    chk8(q, 8'hFF);
    $display("test reset done");
  endtask
  task automatic t_status;
    for (int s = 0; s < 4; s++) begin
      charge_state_in = s[1:0];
      input_power_limit_active = s[0];
      chip_disable_pin = s[1];
      switcher_on = !s[0];
      settle(3);
      host.rd(8'h00, q);
      chk8(q, {s[1:0], 3'b000, s[0], s[1], !s[0]});
    end
    {charge_state_in, input_power_limit_active, chip_disable_pin, switcher_on} = 5'h01;
    host.wr(8'h00, 8'h20);
    chkv(storage_state_request, 13'h1);
    host.rd(8'h00, q);
    chk8(q, 8'h01);
    host.wr(8'h00, 8'h00);
    chkv(storage_state_request, 13'h0);
    charge_state_in = 2'h2;
    settle(3);
    chkv(interrupt_request, 13'h1);
    settle(1);
    chkv(interrupt_request, 13'h0);
    host.wr(8'h02, 8'h80);
    charge_state_in = 2'h0;
    settle(3);
    chkv(interrupt_request, 13'h0);
    host.wr(8'h02, 8'h88);
    $display("test status done");
  endtask
  task automatic t_events;
    {reset_cond_in, timer_fault_in, battery_overcurrent, below_sleep_threshold} = 4'hF;
    settle(3);
    {reset_cond_in, timer_fault_in, battery_overcurrent} = 3'h0;
    settle(8);
    host.rd2(8'h00, q, q2);
    chk8(q, 8'h19);
    chk8(q2, 8'h09);
    host.rd2(8'h01, q, q2);
    chk8(q, 8'h50);
    chk8(q2, 8'h00);
    below_sleep_threshold = 1'b0;
    chkv(interrupt_request, 13'h1);
    host.wr(8'h02, 8'h89);
    chkv(interrupt_request, 13'h0);
    host.wr(8'h02, 8'h88);
    chip_disable_pin = 1'b1;
    settle(4);
    chip_disable_pin = 1'b0;
    settle(4);
    host.rd(8'h00, q);
    chk8(q, 8'h01);
    wake_cond_in = 1'b1;
    settle(4);
    chkv(interrupt_request, 13'h1);
    host.wr(8'h02, 8'h8C);
    chkv(interrupt_request, 13'h0);
    host.wr(8'h02, 8'h88);
    host.rd(8'h00, q);
    chkv(interrupt_request, 13'h0);
    wake_cond_in = 1'b0;
    $display("test events done");
  endtask
  task automatic t_levels;
    {input_overvoltage, battery_lockout} = 2'h3;
    settle(6);
    host.rd2(8'h01, q, q2);
    chk8(q, 8'hA0);
    chk8(q2, 8'hA0);
    chkv(interrupt_request, 13'h1);
    host.wr(8'h01, 8'h0F);
    host.rd(8'h01, q);
    chk8(q, 8'hAF);
    chkv(interrupt_request, 13'h0);
    {input_overvoltage, battery_lockout} = 2'h0;
    settle(4);
    host.wr(8'h01, 8'h00);
    // latched faults show once more after the condition is gone
    host.rd2(8'h01, q, q2);
    chk8(q, 8'hA0);
    chk8(q2, 8'h00);
    $display("test levels done");
  endtask
  task automatic t_charge;
    host.wr(8'h04, 8'h06); // termination pattern before the all-ones code
    for (int i = 0; i < 64; i++) begin
      host.wr(8'h03, {i[5:0], 2'b11});
      e = i[5] ? 40 + 10 * (i % 32) : 5 + i % 32;
      if (i % 32 == 31) chkv(use_external_current, 13'h1);
      else chkv({use_external_current, charge_current_ma}, 13'(e > 300 ? 300 : e));
      chkv({charger_disable, high_impedance_request}, 13'h3);
    end
    host.wr(8'h03, 8'h14);
    chkv({charger_disable, high_impedance_request}, 13'h0);
    for (int i = 0; i < 64; i++) begin
      host.wr(8'h04, {i[5:0], 2'b10});
      e = i[5] ? 12 + 2 * (i % 32) : 1 + i % 32;
      chkv(termination_half_ma, 13'(!i[5] && e > 10 ? 10 : e));
      chkv(termination_active, 13'h1);
    end
    input_power_limit_active = 1'b1;
    settle(3);
    chkv(termination_active, 13'h0);
    input_power_limit_active = 1'b0;
    host.wr(8'h04, 8'h0C);
    chkv(termination_active, 13'h0);
    host.wr(8'h04, 8'h0E);
    $display("test charge done");
  endtask
  task automatic t_thermal;
    for (int i = 0; i < 128; i++) begin
      host.wr(8'h05, {i[6:0], 1'b0});
      e = 3600 + 10 * i;
      chkv(battery_target_voltage, 13'(e > 4650 ? 4650 : e));
    end
    host.wr(8'h05, 8'h78);
    temperature_zone_in = 2'h3;
    settle(3);
    chkv(battery_target_voltage, 13'd4060);
    host.rd(8'h02, q);
    chk8(q, 8'hE8);
    temperature_zone_in = 2'h2;
    settle(3);
    chkv({charge_current_halved, termination_active}, 13'h2);
    temperature_zone_in = 2'h1;
    settle(3);
    chkv(charge_stop, 13'h1);
    host.wr(8'h02, 8'h08);
    chkv({thermistor_enable, charge_stop}, 13'h0);
    host.wr(8'h02, 8'h88);
    temperature_zone_in = 2'h0;
    {thermistor_open_in, open_thermistor_stop_option} = 2'h3;
    settle(3);
    chkv(charge_stop, 13'h1);
    host.rd(8'h02, q);
    chk8(q, 8'h98);
    $display("test thermal done");
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    rst = 1'b1;
    bad_count = 0;
    total_checks = 0;
    {charge_state_in, temperature_zone_in, reset_cond_in, wake_cond_in} = 6'h00;
    {timer_fault_in, input_power_limit_active, chip_disable_pin, input_overvoltage} = 4'h0;
    {below_sleep_threshold, battery_lockout, battery_overcurrent} = 3'h0;
    {thermistor_open_in, open_thermistor_stop_option} = 2'h0;
    switcher_on = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    // live levels need two edges through the synchroniser after reset
    settle(2);
    t_reset();
    t_status();
    t_events();
    t_levels();
    t_charge();
    t_thermal();
    conclude();
  end
  initial begin
    #400000;
    bad_count++;
    $display("watchdog expired");
    conclude();
  end
endmodule
